// *** qadc_pkg.sv ***
// constants, pin carrier and state type of the quad converter sequencer
`default_nettype none
package qadc_pkg;
  localparam int MCLK_NS = 50;
  localparam int CONV_NS = 2500;
  localparam int CONV_CYCLES = 15;
  localparam int INT_TICK_NS = CONV_NS / CONV_CYCLES;
  localparam int INT_TICK_RAW = INT_TICK_NS / MCLK_NS;
  localparam int INT_TICK_CYC = (INT_TICK_RAW < 1) ? 1 : INT_TICK_RAW;
  localparam logic [3:0] INT_DIV_LAST = 4'(INT_TICK_CYC - 1);
  localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
  localparam int NCH = 4;
  localparam int RES_W = 14;
  localparam int IRQ_W = 3;
  localparam int IRQ_CONV = 0;
  localparam int IRQ_SEQ = 1;
  localparam int IRQ_OVR = 2;
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_MASK = 4'h4;
  localparam logic [3:0] ADR_CHSEL = 4'h8;
  localparam logic [3:0] ADR_STATE = 4'hC;
  localparam logic [3:0] CHSEL_RST = 4'hF;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [IRQ_W-1:0] STATUS_RST = 3'h0;

  typedef struct packed {
    logic convertStartN;
    logic deviceSelectN;
    logic readN;
    logic writeN;
    logic pin7;
    logic pin8;
    logic channel3Include;
    logic channel4Include;
    logic hwSwSelect;
    logic [3:0] dataLow;
  } qadc_pins_s;

  typedef enum logic {SEQ_IDLE, SEQ_CONV} qadc_seq_e;
endpackage
`default_nettype wire

// *** qadc_seq_host_port.sv ***
// sequencer, host parallel port and wishbone interrupt registers of the quad converter
//
// What this block does
// - busy rises at the start edge and stays high until all chosen channels finish
// - first-result flag is high exactly while the output pointer selects result 1
// - start rising edge puts all four track/holds into hold and starts converting
// - channel selection is captured at the start edge and used for the sequence
// - bus reads and writes act only while device select is low
// - data outputs are enabled only while read strobe and device select are low
// - write strobe rising with select low and read high stores data bits 0-3
// - in software mode pin seven is the external conversion clock
// - each channel conversion takes exactly fifteen conversion clock cycles
// - in hardware mode pin seven is the include flag of channel 1
// - in software mode pin eight picks internal clock at 0, external at 1
// - in hardware mode pin eight is the include flag of channel 2
// - an include pin at 1 includes its channel, at 0 excludes it
// - hardware mode uses the include pins and internal clock, software mode the register
// - results are 14-bit two's complement with bit 13 the most significant
`timescale 1ns/1ns
`default_nettype none
module qadc_seq_host_port
  import qadc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire qadc_pins_s pinsIn,
  input wire logic [RES_W-1:0] convResult,
  output logic [RES_W-1:0] dbOut,
  output logic dbOe,
  output logic busy,
  output logic firstResultFlag,
  output logic holdAll,
  output logic [1:0] convChannel,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 1 feeds stage 2 only, stage 3 gives edges

  qadc_pins_s pinS1_r;
  qadc_pins_s pinS2_r;
  qadc_pins_s pinS3_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1_r <= '1;
      pinS2_r <= '1;
      pinS3_r <= '1;
    end else begin
      pinS1_r <= pinsIn;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  qadc_seq_e seqState_r;
  logic [NCH-1:0] pending_r;
  logic [NCH-1:0] chanSel_r;
  logic extClk_r;
  logic [3:0] divCnt_r;
  logic [3:0] tickCnt_r;
  logic [2:0] nResults_r;
  logic [1:0] readPtr_r;
  logic [RES_W-1:0] resultMem [NCH];
  logic [RES_W-1:0] dbOut_r;
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] mask_r;
  logic ack_r;
  logic [31:0] rdData_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire startEdge = pinS2_r.convertStartN & ~pinS3_r.convertStartN;
  wire idle = (seqState_r == SEQ_IDLE);
  // hardware mode takes the four include pins, software mode the register
  wire [NCH-1:0] hwSel = {pinS2_r.channel4Include, pinS2_r.channel3Include,
                          pinS2_r.pin8, pinS2_r.pin7};
  wire [NCH-1:0] startSel = pinS2_r.hwSwSelect ? chanSel_r : hwSel;
  wire startSeq = startEdge & idle & (startSel != 4'h0);
  wire overrun = startEdge & ~idle;
  wire startExt = pinS2_r.hwSwSelect & pinS2_r.pin8;

  wire extTick = pinS2_r.pin7 & ~pinS3_r.pin7;
  wire intTick = (divCnt_r == INT_DIV_LAST);
  wire tick = (seqState_r == SEQ_CONV) & (extClk_r ? extTick : intTick);
  wire convDone = tick & (tickCnt_r == CONV_LAST);

  // lowest pending channel converts first
  wire [NCH-1:0] curOne = pending_r & (~pending_r + 4'h1);
  wire [NCH-1:0] remaining = pending_r & ~curOne;
  wire seqDone = convDone & (remaining == 4'h0);
  wire [1:0] curCh = curOne[0] ? 2'h0 : curOne[1] ? 2'h1 : curOne[2] ? 2'h2 : 2'h3;

  wire selected = ~pinS2_r.deviceSelectN;
  wire readDone = pinS2_r.readN & ~pinS3_r.readN & selected;
  wire writeEdge = pinS2_r.writeN & ~pinS3_r.writeN & selected & pinS2_r.readN;
  wire [2:0] ptrInc = {1'b0, readPtr_r} + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seqState_r <= SEQ_IDLE;
      pending_r <= 4'h0;
      extClk_r <= 1'b0;
      divCnt_r <= 4'h0;
      tickCnt_r <= 4'h0;
    end else begin
      unique case (seqState_r)
        SEQ_IDLE: begin
          divCnt_r <= 4'h0;
          tickCnt_r <= 4'h0;
          if (startSeq) begin
            seqState_r <= SEQ_CONV;
            pending_r <= startSel;
            extClk_r <= startExt;
          end
        end
        SEQ_CONV: begin
          // selection and clock-mode pins are not looked at here, so later changes wait for next start
          divCnt_r <= intTick ? 4'h0 : divCnt_r + 4'h1;
          if (tick) begin
            tickCnt_r <= convDone ? 4'h0 : tickCnt_r + 4'h1;
          end
          if (convDone) begin
            pending_r <= remaining;
            if (remaining == 4'h0) begin
              seqState_r <= SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result store and output pointer

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nResults_r <= 3'h0;
      readPtr_r <= 2'h0;
      dbOut_r <= '0;
    end else begin
      dbOut_r <= resultMem[readPtr_r];
      if (startSeq) begin
        nResults_r <= 3'h0;
        readPtr_r <= 2'h0;
      end else begin
        if (convDone) begin
          nResults_r <= nResults_r + 3'h1;
        end
        if (readDone && nResults_r != 3'h0) begin
          readPtr_r <= (ptrInc == nResults_r) ? 2'h0 : ptrInc[1:0];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (convDone) begin
      resultMem[nResults_r[1:0]] <= convResult;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chanSel_r <= CHSEL_RST;
    end else if (writeEdge) begin
      chanSel_r <= pinS2_r.dataLow;
    end
  end

  assign busy = (seqState_r == SEQ_CONV);
  assign holdAll = (seqState_r == SEQ_CONV);
  assign convChannel = curCh;
  assign firstResultFlag = (readPtr_r == 2'h0);
  assign dbOe = selected & ~pinS2_r.readN;
  assign dbOut = dbOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and interrupt registers

  wire wbReq = cyc_i & stb_i;
  wire wbWrite = wbReq & we_i & ack_r & sel_i[0];
  wire [IRQ_W-1:0] irqSet = {overrun, seqDone, convDone};
  wire [IRQ_W-1:0] irqClr = (wbWrite && adr_i == ADR_STATUS) ? dat_i[IRQ_W-1:0] : 3'h0;
  wire [31:0] stateWord = {23'h0, nResults_r, readPtr_r, extClk_r, pinS2_r.hwSwSelect,
                           1'h0, busy};
  wire [31:0] rdMux = (adr_i == ADR_STATUS) ? {29'h0, status_r} :
                      (adr_i == ADR_MASK) ? {29'h0, mask_r} :
                      (adr_i == ADR_CHSEL) ? {28'h0, chanSel_r} :
                      (adr_i == ADR_STATE) ? stateWord : 32'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0;
      status_r <= STATUS_RST;
      mask_r <= MASK_RST;
    end else begin
      ack_r <= wbReq & ~ack_r;
      rdData_r <= (wbReq & ~ack_r) ? rdMux : rdData_r;
      // a new event beats a clear in the same cycle
      status_r <= (status_r & ~irqClr) | irqSet;
      if (wbWrite && adr_i == ADR_MASK) begin
        mask_r <= dat_i[IRQ_W-1:0];
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdData_r;
  assign irq = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_seqBegin;
    startSeq;
  endsequence

  sequence s_intConvBegin;
    $rose(busy) && !extClk_r;
  endsequence

  a_busy_rise: assert property (@(posedge mclk) disable iff (rst)
    s_seqBegin |=> busy && holdAll)
    else $error("busy did not rise after start");

  a_busy_hold: assert property (@(posedge mclk) disable iff (rst)
    busy && !seqDone |=> busy)
    else $error("busy fell before the sequence ended");

  a_first_flag: assert property (@(posedge mclk) disable iff (rst)
    s_seqBegin |=> firstResultFlag && nResults_r == 3'h0)
    else $error("first-result flag not set after start");

  a_sel_capture: assert property (@(posedge mclk) disable iff (rst)
    s_seqBegin |=> pending_r == $past(startSel))
    else $error("selection not captured at start");

  a_pins_ignored: assert property (@(posedge mclk) disable iff (rst)
    busy && !convDone |=> $stable(pending_r) && $stable(extClk_r))
    else $error("selection changed inside a sequence");

  a_bus_deselect: assert property (@(posedge mclk) disable iff (rst)
    pinS2_r.deviceSelectN && !startSeq |=> $stable(chanSel_r) && $stable(readPtr_r))
    else $error("bus acted while not selected");

  a_oe_gate: assert property (@(posedge mclk) disable iff (rst)
    (pinS2_r.readN || pinS2_r.deviceSelectN) |-> !dbOe)
    else $error("data driven outside a read");

  a_chsel_write: assert property (@(posedge mclk) disable iff (rst)
    writeEdge |=> chanSel_r == $past(pinS2_r.dataLow))
    else $error("channel select not written");

  a_conv_length: assert property (@(posedge mclk) disable iff (rst)
    s_intConvBegin |-> !convDone [*8] ##37 convDone)
    else $error("internal conversion length wrong");

  a_clock_mode: assert property (@(posedge mclk) disable iff (rst)
    s_seqBegin |=> extClk_r == ($past(pinS2_r.hwSwSelect) && $past(pinS2_r.pin8)))
    else $error("conversion clock source wrong");

  a_result_count: assert property (@(posedge mclk) disable iff (rst)
    convDone |=> nResults_r == $past(nResults_r) + 3'h1)
    else $error("result not stored");

  a_ptr_wrap: assert property (@(posedge mclk) disable iff (rst)
    readDone && !startSeq && nResults_r != 3'h0 && ptrInc == nResults_r |=> firstResultFlag)
    else $error("pointer did not wrap to result 1");

  sequence s_intConvNext;
    convDone && !seqDone && !extClk_r;
  endsequence

  a_conv_next: assert property (@(posedge mclk) disable iff (rst)
    s_intConvNext |=> !convDone [*8] ##37 convDone)
    else $error("next internal conversion length wrong");

  a_busy_end: assert property (@(posedge mclk) disable iff (rst)
    seqDone |=> !busy)
    else $error("busy stayed high after the last channel");

  a_order_up: assert property (@(posedge mclk) disable iff (rst)
    convDone && !seqDone |=> convChannel > $past(convChannel))
    else $error("channels not converted in ascending order");

  a_hw_select: assert property (@(posedge mclk) disable iff (rst)
    startSeq && !pinS2_r.hwSwSelect |=> pending_r == $past(hwSel) && !extClk_r)
    else $error("hardware mode did not use the include pins");

  a_sw_select: assert property (@(posedge mclk) disable iff (rst)
    startSeq && pinS2_r.hwSwSelect |=> pending_r == $past(chanSel_r))
    else $error("software mode did not use the register");

  a_ext_idle: assert property (@(posedge mclk) disable iff (rst)
    busy && extClk_r && !extTick |=> $stable(tickCnt_r))
    else $error("conversion moved without an external clock edge");

  a_ext_step: assert property (@(posedge mclk) disable iff (rst)
    busy && extClk_r && extTick |=> !$stable(tickCnt_r))
    else $error("external clock edge not counted");

  a_read_step: assert property (@(posedge mclk) disable iff (rst)
    readDone && !startSeq && nResults_r != 3'h0 && ptrInc != nResults_r
    |=> readPtr_r == $past(readPtr_r) + 2'h1)
    else $error("pointer did not advance on a read");

  a_status_set: assert property (@(posedge mclk) disable iff (rst)
    irqSet != 3'h0 |=> (status_r & $past(irqSet)) == $past(irqSet))
    else $error("event did not set its status bit");

  a_ack_once: assert property (@(posedge mclk) disable iff (rst)
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");

  a_ack_answer: assert property (@(posedge mclk) disable iff (rst)
    wbReq && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  a_chsel_quiet: assert property (@(posedge mclk) disable iff (rst)
    !writeEdge |=> $stable(chanSel_r))
    else $error("channel select changed without a write");

endmodule
`default_nettype wire

// *** qadc_host_model.sv ***
// host processor model driving the converter pins over the parallel port
`timescale 1ns/1ns
`default_nettype none
module qadc_host_model
  import qadc_pkg::*;
(
  input wire logic mclk,
  output var qadc_pins_s pins
);
  initial begin
    pins = '1;
    pins.hwSwSelect = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // mode select and include pins {channel 4, channel 3, pin 8, pin 7}
  task automatic setSel(input logic hw, input logic [3:0] inc);
    pins.hwSwSelect <= hw;
    {pins.channel4Include, pins.channel3Include, pins.pin8, pins.pin7} <= inc;
  endtask
  task automatic pulseStart();
    pins.convertStartN <= 1'h0;
    hold(4);
    pins.convertStartN <= 1'h1;
    hold(4);
  endtask
  // write strobe is never touched here
  task automatic busCtl(input logic selN, input logic rdN);
    pins.deviceSelectN <= selN;
    pins.readN <= rdN;
    hold(4);
  endtask
  task automatic writeCh(input logic selN, input logic [3:0] d);
    pins.dataLow <= d;
    pins.deviceSelectN <= selN;
    pins.writeN <= 1'h0;
    hold(4);
    pins.writeN <= 1'h1;
    hold(4);
    pins.deviceSelectN <= 1'h1;
    pins.dataLow <= ~d;
    hold(4);
  endtask
  // even duty cycle on the external conversion clock
  task automatic extTicks(input int n);
    repeat (n) begin
      pins.pin7 <= 1'h1;
      hold(4);
      pins.pin7 <= 1'h0;
      hold(4);
    end
  endtask
endmodule
`default_nettype wire

// *** qadc_seq_host_port_tb.sv ***
// self-checking bench of the quad converter sequencer
`timescale 1ns/1ns
`default_nettype none
module qadc_seq_host_port_tb;
  import qadc_pkg::*;
  logic mclk, rst, cyc, stb, we, ack, dbOe, busy, firstResultFlag, holdAll, irq;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [RES_W-1:0] dbOut;
  logic [1:0] convChannel;
  qadc_pins_s pins;
  int nErrors, cmpCount, n;
  wire logic [RES_W-1:0] convResult = {4'h8, 8'h00, convChannel};
  qadc_host_model qadc_host_model_i (.mclk(mclk), .pins(pins));
  qadc_seq_host_port qadc_seq_host_port_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .pinsIn(pins), .convResult(convResult), .dbOut(dbOut), .dbOe(dbOe), .busy(busy),
    .firstResultFlag(firstResultFlag), .holdAll(holdAll), .convChannel(convChannel), .irq(irq));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    if (ack !== 1'h1) begin
      nErrors++;
      conclude();
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge mclk);
  endtask
  // counts cycles until busy reaches the level, bounded
  task automatic waitBusy(input logic lvl, input int bound);
    n = 0;
    while (busy !== lvl && n < bound) begin
      @(posedge mclk);
      n++;
    end
    if (n >= bound) begin
      nErrors++;
      conclude();
    end
  endtask
  task automatic readSlot(input logic [RES_W-1:0] exp, input logic first);
    qadc_host_model_i.busCtl(1'h0, 1'h0);
    check(dbOe, 1'h1, "data outputs not enabled");
    check(dbOut, exp, "result slot value");
    check(firstResultFlag, first, "first result flag");
    qadc_host_model_i.busCtl(1'h0, 1'h1);
    check(dbOe, 1'h0, "data outputs left enabled");
    qadc_host_model_i.busCtl(1'h1, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tReset();
    check(busy, 1'h0, "busy after reset");
    check(firstResultFlag, 1'h1, "flag after reset");
    wb(1'h0, ADR_CHSEL, 32'h0);
    check(q, 32'hF, "channel select reset");
    wb(1'h0, 4'h2, 32'h0);
    check(q, 32'h0, "unmapped read");
    $display("reset test done");
  endtask
  task automatic tHwSeq();
    qadc_host_model_i.setSel(1'h0, 4'h5);
    qadc_host_model_i.pulseStart();
    check({busy, holdAll}, 2'h3, "busy or hold missing");
    qadc_host_model_i.setSel(1'h0, 4'h7);
    waitBusy(1'h0, 300);
    check(32'(n >= 80 && n <= 95), 32'h1, "two channel busy time");
    readSlot(14'h2000, 1'h1);
    readSlot(14'h2002, 1'h0);
    readSlot(14'h2000, 1'h1);
    $display("hardware sequence test done");
  endtask
  task automatic tSwSeq();
    qadc_host_model_i.setSel(1'h1, 4'h5);
    qadc_host_model_i.writeCh(1'h0, 4'h8);
    qadc_host_model_i.writeCh(1'h1, 4'h1);
    wb(1'h0, ADR_CHSEL, 32'h0);
    check(q, 32'h8, "channel select register");
    qadc_host_model_i.busCtl(1'h1, 1'h0);
    check(dbOe, 1'h0, "outputs on while deselected");
    qadc_host_model_i.busCtl(1'h1, 1'h1);
    qadc_host_model_i.pulseStart();
    waitBusy(1'h0, 100);
    check(32'(n >= 38 && n <= 48), 32'h1, "one channel busy time");
    readSlot(14'h2003, 1'h1);
    $display("software sequence test done");
  endtask
  task automatic tExtClk();
    qadc_host_model_i.setSel(1'h1, 4'h6);
    qadc_host_model_i.pulseStart();
    qadc_host_model_i.pulseStart();
    check(busy, 1'h1, "start while busy ended the run");
    qadc_host_model_i.extTicks(14);
    check(busy, 1'h1, "finished before fifteen ticks");
    qadc_host_model_i.extTicks(1);
    waitBusy(1'h0, 10);
    $display("external clock test done");
  endtask
  task automatic tIrq();
    check(irq, 1'h0, "interrupt while masked");
    wb(1'h0, ADR_STATE, 32'h0);
    check(q, 32'h4C, "state word after external run");
    wb(1'h0, ADR_STATUS, 32'h0);
    check(q, 32'h7, "status after sequences");
    wb(1'h1, ADR_MASK, 32'h2);
    wb(1'h0, ADR_MASK, 32'h0);
    check(q, 32'h2, "mask readback");
    check(irq, 1'h1, "unmasked interrupt");
    wb(1'h1, ADR_STATUS, 32'h2);
    check(irq, 1'h0, "interrupt after clear");
    wb(1'h1, ADR_STATUS, 32'h7);
    wb(1'h0, ADR_STATUS, 32'h0);
    check(q, 32'h0, "status after clear");
    $display("interrupt test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 4'h0; sel = 4'hF; wdat = 32'h0;
    nErrors = 0; cmpCount = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
    tReset();
    tHwSeq();
    tSwSeq();
    tExtClk();
    tIrq();
    conclude();
  end
endmodule
`default_nettype wire
